/* File: verilog/ppcm_top.sv */
// Host-bus misc configuration register with clock gating and clock-run control.
// Assumes config cycles arrive on ref_clk; host reset and CLKRUN# are async pins.
`timescale 1ns/1ps
`default_nettype none
`include "ppcm_map.svh"

module ppcm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hostResetN,
  input wire logic d3ToD0Reset,
  input wire ppcm_pkg::ppcm_cfg_req_t cfgReq,
  output logic [31:0] cfgRdata,
  output logic cfgAck,
  input wire logic linkBusy,
  input wire logic hostBusy,
  output logic linkClkEn,
  output logic hostClkEn,
  output logic wakeFromDeepestSleepAdvertise,
  output logic wakeFromLightSleepAdvertise,
  output logic lightSleepStateAdvertise,
  input wire logic clkrunInN,
  output logic clkrunOutN,
  output logic clkrunOe
);

  ppcm_pkg::ppcm_state_t state_reg;
  ppcm_pkg::ppcm_state_t state_next;
  logic hostResetLevelN;
  logic clkrunLevelN;
  logic fnReset;
  logic hit;
  logic [31:0] cfgView;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  ppcm_sync3 #(.RESET_VALUE(1'b1)) u_host_rst_sync (
    .clk(ref_clk),
    .rst(rst),
    .pinIn(hostResetN),
    .levelOut(hostResetLevelN)
  );

  ppcm_sync3 #(.RESET_VALUE(1'b0)) u_clkrun_sync (
    .clk(ref_clk),
    .rst(rst),
    .pinIn(clkrunInN),
    .levelOut(clkrunLevelN)
  );

  // Host reset and D3-to-D0 reset act on the function, not on sticky bits
  assign fnReset = !hostResetLevelN || d3ToD0Reset;
  assign hit = (cfgReq.addr == `PPCM_CFG_OFFSET);

  // ----------------------------------------
  // Read view
  // ----------------------------------------
  always_comb begin
    cfgView = 32'h00000000;
    cfgView[`PPCM_BIT_WAKE_DEEP] = state_reg.wakeDeep;
    cfgView[`PPCM_BIT_WAKE_LIGHT] = state_reg.wakeLight;
    cfgView[`PPCM_BIT_LIGHT_SLEEP] = state_reg.lightSleep;
    cfgView[`PPCM_BIT_SPARE] = state_reg.spare;
    cfgView[`PPCM_BIT_LINK_GATE_OFF] = state_reg.linkGateOff;
    cfgView[`PPCM_BIT_HOST_GATE_OFF] = state_reg.hostGateOff;
    cfgView[`PPCM_BIT_KEEP_HOST_CLK] = state_reg.keepHostClock;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.ack = cfgReq.rd || cfgReq.wr;
    state_next.rdata = 32'h00000000;
    if (cfgReq.rd && hit) begin
      state_next.rdata = cfgView;
    end
    // Non-sticky bits fall back on function reset; sticky ones hold
    if (fnReset) begin
      state_next.spare = 1'b0;
      state_next.linkGateOff = 1'b0;
      state_next.hostGateOff = 1'b0;
      state_next.keepHostClock = 1'b0;
    end else if (cfgReq.wr && hit && cfgReq.be[0]) begin
      state_next.spare = cfgReq.wdata[`PPCM_BIT_SPARE];
      state_next.linkGateOff = cfgReq.wdata[`PPCM_BIT_LINK_GATE_OFF];
      state_next.hostGateOff = cfgReq.wdata[`PPCM_BIT_HOST_GATE_OFF];
      state_next.keepHostClock = cfgReq.wdata[`PPCM_BIT_KEEP_HOST_CLK];
    end
    if (cfgReq.wr && hit && cfgReq.be[1]) begin
      state_next.wakeDeep = cfgReq.wdata[`PPCM_BIT_WAKE_DEEP];
      state_next.wakeLight = cfgReq.wdata[`PPCM_BIT_WAKE_LIGHT];
      state_next.lightSleep = cfgReq.wdata[`PPCM_BIT_LIGHT_SLEEP];
    end
    // Enables are registered so an external gate cell sees clean edges
    if (state_reg.linkGateOff || linkBusy) begin
      state_next.linkIdle = `PPCM_IDLE_CYCLES;
    end else if (state_reg.linkIdle != 8'h00) begin
      state_next.linkIdle = state_reg.linkIdle - 8'h01;
    end
    if (state_reg.hostGateOff || hostBusy) begin
      state_next.hostIdle = `PPCM_IDLE_CYCLES;
    end else if (state_reg.hostIdle != 8'h00) begin
      state_next.hostIdle = state_reg.hostIdle - 8'h01;
    end
    state_next.linkClkEn = state_reg.linkGateOff || linkBusy
      || (state_reg.linkIdle != 8'h00);
    state_next.hostClkEn = state_reg.hostGateOff || hostBusy
      || (state_reg.hostIdle != 8'h00);
    // CLKRUN# high means the central resource wants to stop the clock
    state_next.clkrunOutN = 1'b0;
    if (state_reg.clkrunCnt != 3'h0) begin
      state_next.clkrunCnt = state_reg.clkrunCnt - 3'h1;
      state_next.clkrunOe = (state_reg.clkrunCnt != 3'h1);
    end else if (clkrunLevelN && (state_reg.keepHostClock || hostBusy)) begin
      state_next.clkrunCnt = `PPCM_CLKRUN_DRIVE;
      state_next.clkrunOe = 1'b1;
    end else begin
      state_next.clkrunOe = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.wakeLight <= 1'b1;
      state_reg.lightSleep <= 1'b1;
      state_reg.linkIdle <= `PPCM_IDLE_CYCLES;
      state_reg.hostIdle <= `PPCM_IDLE_CYCLES;
      state_reg.linkClkEn <= 1'b1;
      state_reg.hostClkEn <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfgRdata = state_reg.rdata;
  assign cfgAck = state_reg.ack;
  assign linkClkEn = state_reg.linkClkEn;
  assign hostClkEn = state_reg.hostClkEn;
  assign wakeFromDeepestSleepAdvertise = state_reg.wakeDeep;
  assign wakeFromLightSleepAdvertise = state_reg.wakeLight;
  assign lightSleepStateAdvertise = state_reg.lightSleep;
  assign clkrunOutN = state_reg.clkrunOutN;
  assign clkrunOe = state_reg.clkrunOe;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfgReq.rd && hit) |=> ((cfgRdata & ~`PPCM_CFG_WMASK) == 32'h00000000))
    else $error("reserved bits read nonzero");

  reset_value_a: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> (cfgView == `PPCM_CFG_RESET))
    else $error("register reset value wrong");

  deep_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fnReset && !(cfgReq.wr && hit)) |=> $stable(wakeFromDeepestSleepAdvertise))
    else $error("deep wake bit lost on function reset");

  light_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fnReset && !(cfgReq.wr && hit)) |=> $stable(lightSleepStateAdvertise)
      && $stable(wakeFromLightSleepAdvertise))
    else $error("light sleep bits lost on function reset");

  spare_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfgReq.wr && hit && cfgReq.be[0] && !fnReset)
      |=> (state_reg.spare == $past(cfgReq.wdata[`PPCM_BIT_SPARE])))
    else $error("spare bit write not stored");

  link_ungated_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg.linkGateOff |=> linkClkEn)
    else $error("link clock gated while gating off");

  host_ungated_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg.hostGateOff |=> hostClkEn)
    else $error("host clock gated while gating off");

  keep_request_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkrunLevelN && state_reg.keepHostClock && state_reg.clkrunCnt == 3'h0)
      |=> clkrunOe ##1 clkrunOe ##1 !clkrunOe)
    else $error("clock stop not refused");

  allow_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!state_reg.keepHostClock && !hostBusy && state_reg.clkrunCnt == 3'h0) |=> !clkrunOe)
    else $error("clock stop refused while allowed");

  idle_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!state_reg.linkGateOff && !linkBusy) [*8] ##1 (!state_reg.linkGateOff && !linkBusy) [*8]
      ##1 (!state_reg.linkGateOff && !linkBusy) [*2] |=> !linkClkEn)
    else $error("link clock not gated after idle");

  busy_ungate_a: assert property (@(posedge ref_clk) disable iff (rst)
    linkBusy |=> linkClkEn)
    else $error("link clock not ungated for activity");

  full_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfgReq.wr && hit && !fnReset && cfgReq.be == 4'hf)
      |=> (cfgView == ($past(cfgReq.wdata) & `PPCM_CFG_WMASK)))
    else $error("full write stored wrong bits");

  write_cover: cover property (@(posedge ref_clk) disable iff (rst) cfgReq.wr && hit);
  refuse_cover: cover property (@(posedge ref_clk) disable iff (rst)
    clkrunOe && state_reg.keepHostClock);
  gate_cover: cover property (@(posedge ref_clk) disable iff (rst) $fell(linkClkEn));

endmodule

`default_nettype wire

/* File: verilog/ppcm_map.svh */
// Offsets, field positions, reset values and counts of the misc config register.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PPCM_MAP_SVH
`define PPCM_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PPCM_CFG_OFFSET 8'hf0
`define PPCM_CFG_RESET 32'h00002400
`define PPCM_CFG_WMASK 32'h0000a40f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPCM_BIT_WAKE_DEEP 15
`define PPCM_BIT_WAKE_LIGHT 13
`define PPCM_BIT_LIGHT_SLEEP 10
`define PPCM_BIT_SPARE 3
`define PPCM_BIT_LINK_GATE_OFF 2
`define PPCM_BIT_HOST_GATE_OFF 1
`define PPCM_BIT_KEEP_HOST_CLK 0

// ----------------------------------------
// Timing counts in ref_clk cycles
// ----------------------------------------
`define PPCM_IDLE_CYCLES 8'h10
`define PPCM_CLKRUN_DRIVE 3'h2

`endif

/* File: verilog/ppcm_pkg.sv */
// Types shared by the misc config register block.
// Assumes ppcm_map.svh is on the include path.
`default_nettype none
`include "ppcm_map.svh"

package ppcm_pkg;

  // ----------------------------------------
  // Configuration access request
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ppcm_cfg_req_t;

  // ----------------------------------------
  // Whole state of the top module
  // ----------------------------------------
  typedef struct packed {
    logic wakeDeep;
    logic wakeLight;
    logic lightSleep;
    logic spare;
    logic linkGateOff;
    logic hostGateOff;
    logic keepHostClock;
    logic [31:0] rdata;
    logic ack;
    logic [7:0] linkIdle;
    logic [7:0] hostIdle;
    logic linkClkEn;
    logic hostClkEn;
    logic [2:0] clkrunCnt;
    logic clkrunOe;
    logic clkrunOutN;
  } ppcm_state_t;

  // ----------------------------------------
  // Pin synchroniser state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } ppcm_sync_state_t;

endpackage

`default_nettype wire

/* File: verilog/ppcm_sync3.sv */
// Three-flop synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to clk; output changes once flops 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none

module ppcm_sync3 #(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic levelOut
);

  ppcm_pkg::ppcm_sync_state_t sync_reg;
  ppcm_pkg::ppcm_sync_state_t sync_next;

  // First stage is read only by the second
  always_comb begin
    sync_next = sync_reg;
    sync_next.stage = {sync_reg.stage[1:0], pinIn};
    // Agreement of two flops filters a pin that settles late
    if (sync_reg.stage[1] == sync_reg.stage[2]) begin
      sync_next.level = sync_reg.stage[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= {{3{RESET_VALUE}}, RESET_VALUE};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign levelOut = sync_reg.level;

endmodule

`default_nettype wire

/* File: tb/ppcm_clkrun_central.sv */
// Model of the central clock resource on the open-drain CLKRUN# wire.
// Assumes a pull-up on the wire and that the block drives low only with its enable high.
`timescale 1ns/1ps
`default_nettype none
module ppcm_clkrun_central (
  input wire logic stopReq,
  input wire logic clkrunOe,
  input wire logic clkrunOutN,
  output logic clkrunInN
);
  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // Central holds the wire low while the clock runs and releases it to ask for a stop.
  // Pull-up wins only when nobody drives low.
  assign clkrunInN = !(!stopReq || (clkrunOe && !clkrunOutN));
endmodule
`default_nettype wire

/* File: tb/tb_pci_power_clock_misc_config.sv */
// Self-checking bench for the misc config register block.
// Assumes ppcm_pkg, ppcm_top and the clock-run central model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pci_power_clock_misc_config;
  typedef struct {
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] expRd;
  } ppcm_row_t;
  logic ref_clk, rst, hostResetN, d3ToD0Reset, linkBusy, hostBusy, stopReq;
  logic cfgAck, linkClkEn, hostClkEn, wDeep, wLight, lSleep;
  logic clkrunInN, clkrunOutN, clkrunOe, seen;
  logic [31:0] cfgRdata, rd;
  ppcm_pkg::ppcm_cfg_req_t cfgReq;
  int n_errors, checks_done, i, k;
  ppcm_row_t rows [6] = '{
    '{8'hf0, 4'hf, 32'hffffffff, 32'h0000a40f},
    '{8'hf0, 4'hf, 32'h00000000, 32'h00000000},
    '{8'hf4, 4'hf, 32'hffffffff, 32'h00000000},
    '{8'hf0, 4'h1, 32'h0000ffff, 32'h0000000f},
    '{8'hf0, 4'h2, 32'h0000ffff, 32'h0000a40f},
    '{8'hf0, 4'hc, 32'h00000000, 32'h0000a40f}
  };

  ppcm_top i_ppcm_top (
    .ref_clk(ref_clk),
    .rst(rst),
    .hostResetN(hostResetN),
    .d3ToD0Reset(d3ToD0Reset),
    .cfgReq(cfgReq),
    .cfgRdata(cfgRdata),
    .cfgAck(cfgAck),
    .linkBusy(linkBusy),
    .hostBusy(hostBusy),
    .linkClkEn(linkClkEn),
    .hostClkEn(hostClkEn),
    .wakeFromDeepestSleepAdvertise(wDeep),
    .wakeFromLightSleepAdvertise(wLight),
    .lightSleepStateAdvertise(lSleep),
    .clkrunInN(clkrunInN),
    .clkrunOutN(clkrunOutN),
    .clkrunOe(clkrunOe)
  );

  ppcm_clkrun_central i_ppcm_clkrun_central (
    .stopReq(stopReq),
    .clkrunOe(clkrunOe),
    .clkrunOutN(clkrunOutN),
    .clkrunInN(clkrunInN)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One access; ack and read data stand for the single cycle after the request
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    cyc(1);
    cfgReq = '{rd: !w, wr: w, addr: a, be: b, wdata: d};
    cyc(1);
    cfgReq = '0;
    chk("cfgAck", 32'h1, {31'h0, cfgAck});
    rd = cfgRdata;
  endtask

  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    hostResetN = 1'b1;
    d3ToD0Reset = 1'b0;
    linkBusy = 1'b0;
    hostBusy = 1'b0;
    stopReq = 1'b0;
    cfgReq = '0;
    rd = '0;
    seen = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    acc(1'b0, 8'hf0, 4'hf, 32'h0);
    chk("reset value", 32'h00002400, rd);
    chk("advertise", 32'h3, {29'h0, wDeep, wLight, lSleep});
    // Ordinary write then read-back rows; row 1 plays software clearing all three advertise bits
    for (i = 0; i < 6; i++) begin
      acc(1'b1, rows[i].addr, rows[i].be, rows[i].wdata);
      acc(1'b0, 8'hf0, 4'hf, 32'h0);
      chk("readback", rows[i].expRd, rd);
      chk("advertise", {29'h0, rows[i].expRd[15], rows[i].expRd[13], rows[i].expRd[10]},
          {29'h0, wDeep, wLight, lSleep});
    end
    // Host reset and D3-to-D0 reset keep the advertise bits
    for (k = 0; k < 2; k++) begin
      acc(1'b1, 8'hf0, 4'hf, 32'hffffffff);
      hostResetN = (k != 0);
      d3ToD0Reset = (k == 1);
      cyc(6);
      hostResetN = 1'b1;
      d3ToD0Reset = 1'b0;
      cyc(6);
      acc(1'b0, 8'hf0, 4'hf, 32'h0);
      chk("sticky bits", 32'h0000a400, rd);
    end
    // Mid-run reset restores every bit, sticky ones included
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    chk("enables after reset", 32'h3, {30'h0, linkClkEn, hostClkEn});
    chk("advertise after reset", 32'h3, {29'h0, wDeep, wLight, lSleep});
    acc(1'b0, 8'hf0, 4'hf, 32'h0);
    chk("reset value again", 32'h00002400, rd);
    // Gating: link then host clock, idle timeout, then gate-off bit holds it on
    for (i = 0; i < 2; i++) begin
      acc(1'b1, 8'hf0, 4'h1, 32'h0);
      cyc(30);
      linkBusy = (i == 0);
      hostBusy = (i == 1);
      cyc(1);
      linkBusy = 1'b0;
      hostBusy = 1'b0;
      cyc(10);
      chk("clock on", 32'h1, {31'h0, (i == 0) ? linkClkEn : hostClkEn});
      cyc(10);
      chk("clock gated", 32'h0, {31'h0, (i == 0) ? linkClkEn : hostClkEn});
      acc(1'b1, 8'hf0, 4'h1, (i == 0) ? 32'h4 : 32'h2);
      cyc(30);
      chk("gate off", 32'h1, {31'h0, (i == 0) ? linkClkEn : hostClkEn});
    end
    // Clock run: stop allowed with bit 0 clear, refused with it set
    acc(1'b1, 8'hf0, 4'h1, 32'h0);
    stopReq = 1'b1;
    for (k = 0; k < 20; k++) begin
      cyc(1);
      seen = seen | clkrunOe;
    end
    chk("clkrun idle", 32'h0, {31'h0, seen});
    // Host activity alone also asks the clock to keep running
    hostBusy = 1'b1;
    seen = 1'b0;
    for (k = 0; k < 20 && !seen; k++) begin
      cyc(1);
      seen = (clkrunOe === 1'b1);
    end
    chk("clkrun busy", 32'h1, {31'h0, seen});
    hostBusy = 1'b0;
    cyc(5);
    chk("clkrun released", 32'h0, {31'h0, clkrunOe});
    acc(1'b1, 8'hf0, 4'h1, 32'h1);
    seen = 1'b0;
    for (k = 0; k < 20 && !seen; k++) begin
      cyc(1);
      seen = (clkrunOe === 1'b1);
    end
    chk("clkrun keep", 32'h1, {31'h0, seen});
    chk("clkrun wire", 32'h0, {31'h0, clkrunInN});
    chk("clkrun drive level", 32'h0, {31'h0, clkrunOutN});
    stopReq = 1'b0;
    complete_run();
  end

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
